/* rtl/crc_top.sv */
// Chosen here: the AHB-Lite register port.
`include "crc_regs.svh"

module crc_top #(
   parameter int RTC_BASE_EDGES = `CRC_RTC_BASE_EDGES
) (
   // Clock and power-on reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Reset sources and system reset
   input wire logic reset_pin_n_i,
   input wire logic low_supply_detector_i,
   output logic system_reset_o,
   // Factory code options, caught during reset
   input wire crc_pkg::crc_osc_type_e fast_osc_type_i,
   input wire logic clock_halve_i,
   // Oscillator pins and controls
   input wire logic fast_oscillator_i,
   input wire logic slow_oscillator_i,
   input wire logic internal_rc_i,
   output logic fast_osc_enable_o,
   output logic slow_osc_enable_o,
   output logic slow_osc_rc_mode_o,
   output logic osc_output_pin_o,
   output logic osc_output_pin_oe_o,
   // Clock enables
   output logic system_clock_o,
   output logic instruction_clock_o,
   output logic watchdog_tick_o,
   output logic basic_timer_tick_o,
   input wire logic basic_timer_timebase_select_i,
   // Operating mode
   input wire logic wakeup_i,
   output logic cpu_run_o,
   output logic green_mode_o,
   output logic sleep_mode_o,
   output logic slow_mode_o,
   output logic watchdog_clear_o,
   output logic watchdog_period_select_o,
   output logic [1:0] rtc_period_o,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o
);
   import crc_pkg::*;

   localparam int RTC_W = 18;

   initial begin
      if (RTC_BASE_EDGES < 1 || RTC_BASE_EDGES > (1 << (RTC_W - 4))) begin
         $error("crc_top: RTC_BASE_EDGES out of range");
      end
   end

   // Reset pin and detector synchronisers
   logic pin_meta_n;
   logic pin_sync_n;
   logic lvd_meta;
   logic lvd_sync;
   logic sys_rst;
   logic next_sys_rst;

   always_comb begin
      next_sys_rst = ~pin_sync_n | lvd_sync;
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pin_meta_n <= 1'b0;
         pin_sync_n <= 1'b0;
         lvd_meta <= 1'b1;
         lvd_sync <= 1'b1;
         sys_rst <= 1'b1;
      end else begin
         pin_meta_n <= reset_pin_n_i;
         pin_sync_n <= pin_meta_n;
         lvd_meta <= low_supply_detector_i;
         lvd_sync <= lvd_meta;
         sys_rst <= next_sys_rst;
      end
   end

   assign system_reset_o = sys_rst;

   // Factory options are latched while the system is held in reset
   crc_osc_type_e opt_type;
   logic opt_halve;
   crc_osc_type_e next_opt_type;
   logic next_opt_halve;

   always_comb begin
      next_opt_type = opt_type;
      next_opt_halve = opt_halve;
      if (sys_rst) begin
         next_opt_type = fast_osc_type_i;
         next_opt_halve = clock_halve_i;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         opt_type <= OSC_RC;
         opt_halve <= 1'b0;
      end else begin
         opt_type <= next_opt_type;
         opt_halve <= next_opt_halve;
      end
   end

   logic rc_mode;
   logic halve_instruction_clock;
   assign rc_mode = (opt_type == OSC_RC);
   assign halve_instruction_clock = opt_halve | rc_mode;

   // Oscillator edge detection
   logic [2:0] osc_rise;

   crc_osc_sync #(
      .WIDTH(3)
   ) u_osc_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .osc_i({internal_rc_i, slow_oscillator_i, fast_oscillator_i}),
      .level_o(),
      .rise_o(osc_rise)
   );

   // Registers
   crc_reg_t opt_reg;
   crc_reg_t oscillator_mode_control_reg;
   crc_reg_t next_opt_reg;
   crc_reg_t next_oscillator_mode_control_reg;

   logic fast_stop;
   logic slow_sel;
   crc_cpu_mode_e cpu_mode;
   assign fast_stop = oscillator_mode_control_reg[`CRC_OSCILLATOR_MODE_CONTROL_FAST_STOP_BIT];
   assign slow_sel = oscillator_mode_control_reg[`CRC_OSCILLATOR_MODE_CONTROL_SLOW_SEL_BIT];
   assign cpu_mode = crc_cpu_mode_e'({oscillator_mode_control_reg[`CRC_OSCILLATOR_MODE_CONTROL_CPU_HI_BIT],
                                      oscillator_mode_control_reg[`CRC_OSCILLATOR_MODE_CONTROL_CPU_LO_BIT]});

   logic sleeping;
   logic fast_run;
   logic slow_run;
   assign sleeping = (cpu_mode == CPU_SLEEP);
   assign fast_run = ~fast_stop & ~sleeping;
   assign slow_run = ~sleeping;

   // RC mode halves the raw oscillator ahead of the clock path
   logic fast_half;
   logic next_fast_half;
   logic fast_edge;
   logic slow_edge;

   always_comb begin
      next_fast_half = fast_half;
      if (osc_rise[0] & fast_run) begin
         next_fast_half = ~fast_half;
      end
   end

   assign fast_edge = osc_rise[0] & fast_run & (~rc_mode | fast_half);
   assign slow_edge = osc_rise[1] & slow_run;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         fast_half <= 1'b0;
      end else if (sys_rst) begin
         fast_half <= 1'b0;
      end else begin
         fast_half <= next_fast_half;
      end
   end

   // Source switch: the old source is left in any cycle without its edge, then the new
   // source is taken at its own edge, so no two system clock pulses come back to back
   crc_switch_e sw_state;
   crc_switch_e next_sw_state;
   logic sys_edge;
   logic next_sys_edge;

   always_comb begin
      next_sw_state = sw_state;
      next_sys_edge = 1'b0;
      case (sw_state)
         SW_FAST: begin
            next_sys_edge = fast_edge;
            if (slow_sel & ~fast_edge) begin
               next_sw_state = SW_TO_SLOW;
            end
         end
         SW_TO_SLOW: begin
            if (slow_edge) begin
               next_sys_edge = 1'b1;
               next_sw_state = SW_SLOW;
            end
         end
         SW_SLOW: begin
            next_sys_edge = slow_edge;
            if (~slow_sel & ~slow_edge) begin
               next_sw_state = SW_TO_FAST;
            end
         end
         SW_TO_FAST: begin
            if (fast_edge) begin
               next_sys_edge = 1'b1;
               next_sw_state = SW_FAST;
            end
         end
         default: begin
            next_sw_state = SW_FAST;
         end
      endcase
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sw_state <= SW_FAST;
         sys_edge <= 1'b0;
      end else if (sys_rst) begin
         sw_state <= SW_FAST;
         sys_edge <= 1'b0;
      end else begin
         sw_state <= next_sw_state;
         sys_edge <= next_sys_edge;
      end
   end

   // Instruction clock divider and square wave for the output pin
   logic [2:0] div_cnt;
   logic [2:0] next_div_cnt;
   logic [2:0] div_last;
   logic instruction_clock;
   logic next_instruction_clock;
   logic sq_wave;
   logic next_sq_wave;

   assign div_last = halve_instruction_clock ? 3'(`CRC_INSTRUCTION_CLOCK_DIV_HALVED - 1)
                                : 3'(`CRC_INSTRUCTION_CLOCK_DIV - 1);

   always_comb begin
      next_div_cnt = div_cnt;
      next_instruction_clock = 1'b0;
      next_sq_wave = sq_wave;
      if (sys_edge) begin
         if (div_cnt >= div_last) begin
            next_div_cnt = 3'h0;
            next_instruction_clock = 1'b1;
         end else begin
            next_div_cnt = div_cnt + 3'h1;
         end
         next_sq_wave = (next_div_cnt < {1'b0, div_last[2:1]} + 3'h1);
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         div_cnt <= 3'h0;
         instruction_clock <= 1'b0;
         sq_wave <= 1'b0;
      end else if (sys_rst) begin
         div_cnt <= 3'h0;
         instruction_clock <= 1'b0;
         sq_wave <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         instruction_clock <= next_instruction_clock;
         sq_wave <= next_sq_wave;
      end
   end

   // Real-time clock period counter on slow oscillator edges
   logic [RTC_W-1:0] rtc_cnt;
   logic [RTC_W-1:0] next_rtc_cnt;
   logic [RTC_W-1:0] rtc_last;
   logic rtc_tick;
   logic next_rtc_tick;
   logic [1:0] rtc_sel;

   assign rtc_sel = {opt_reg[`CRC_OPT_RTC_HI_BIT], opt_reg[`CRC_OPT_RTC_LO_BIT]};
   assign rtc_last = RTC_W'(RTC_BASE_EDGES * (1 << rtc_sel) - 1);

   always_comb begin
      next_rtc_cnt = rtc_cnt;
      next_rtc_tick = 1'b0;
      if (slow_edge) begin
         if (rtc_cnt >= rtc_last) begin
            next_rtc_cnt = '0;
            next_rtc_tick = 1'b1;
         end else begin
            next_rtc_cnt = rtc_cnt + RTC_W'(1);
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rtc_cnt <= '0;
         rtc_tick <= 1'b0;
      end else if (sys_rst) begin
         rtc_cnt <= '0;
         rtc_tick <= 1'b0;
      end else begin
         rtc_cnt <= next_rtc_cnt;
         rtc_tick <= next_rtc_tick;
      end
   end

   // AHB-Lite slave: zero wait states, always OKAY
   logic wr_pend;
   logic [9:0] wr_idx;
   logic next_wr_pend;
   logic [9:0] next_wr_idx;
   logic [31:0] next_hrdata;
   logic addr_phase;
   crc_reg_t status_val;

   assign addr_phase = hsel_i & hready_i & htrans_i[1];
   assign status_val = {1'b0, halve_instruction_clock, opt_type, slow_run, fast_run, sw_state};

   always_comb begin
      next_opt_reg = opt_reg;
      next_oscillator_mode_control_reg = oscillator_mode_control_reg;
      if (wr_pend) begin
         if (wr_idx == `CRC_IDX_OPTION) begin
            next_opt_reg = hwdata_i[7:0] & `CRC_OPT_WMASK;
         end else if (wr_idx == `CRC_IDX_OSCILLATOR_MODE_CONTROL) begin
            next_oscillator_mode_control_reg = hwdata_i[7:0] & `CRC_OSCILLATOR_MODE_CONTROL_WMASK;
         end
      end else if (wakeup_i & (cpu_mode == CPU_GREEN || cpu_mode == CPU_SLEEP)) begin
         next_oscillator_mode_control_reg[`CRC_OSCILLATOR_MODE_CONTROL_CPU_HI_BIT] = 1'b0;
         next_oscillator_mode_control_reg[`CRC_OSCILLATOR_MODE_CONTROL_CPU_LO_BIT] = 1'b0;
      end
   end

   always_comb begin
      next_wr_pend = addr_phase & hwrite_i;
      next_wr_idx = haddr_i[11:2];
      next_hrdata = hrdata_o;
      if (addr_phase & ~hwrite_i) begin
         if (haddr_i[11:2] == `CRC_IDX_OPTION) begin
            next_hrdata = {24'h000000, next_opt_reg};
         end else if (haddr_i[11:2] == `CRC_IDX_OSCILLATOR_MODE_CONTROL) begin
            next_hrdata = {24'h000000, next_oscillator_mode_control_reg};
         end else if (haddr_i[11:2] == `CRC_IDX_STATUS) begin
            next_hrdata = {24'h000000, status_val};
         end else begin
            next_hrdata = 32'h00000000;
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         opt_reg <= `CRC_OPT_RESET;
         oscillator_mode_control_reg <= `CRC_OSCILLATOR_MODE_CONTROL_RESET;
         wr_pend <= 1'b0;
         wr_idx <= 10'h000;
         hrdata_o <= 32'h00000000;
      end else if (sys_rst) begin
         opt_reg <= `CRC_OPT_RESET;
         oscillator_mode_control_reg <= `CRC_OSCILLATOR_MODE_CONTROL_RESET;
         wr_pend <= 1'b0;
         wr_idx <= 10'h000;
         hrdata_o <= 32'h00000000;
      end else begin
         opt_reg <= next_opt_reg;
         oscillator_mode_control_reg <= next_oscillator_mode_control_reg;
         wr_pend <= next_wr_pend;
         wr_idx <= next_wr_idx;
         hrdata_o <= next_hrdata;
      end
   end

   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   // Outputs
   logic wd_tick;
   logic tm_tick;
   logic next_wd_tick;
   logic next_tm_tick;

   always_comb begin
      next_wd_tick = oscillator_mode_control_reg[`CRC_OSCILLATOR_MODE_CONTROL_WD_SRC_BIT] ? osc_rise[2] : instruction_clock;
      next_tm_tick = basic_timer_timebase_select_i ? rtc_tick : instruction_clock;
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wd_tick <= 1'b0;
         tm_tick <= 1'b0;
      end else begin
         wd_tick <= next_wd_tick;
         tm_tick <= next_tm_tick;
      end
   end

   assign watchdog_tick_o = wd_tick;
   assign basic_timer_tick_o = tm_tick;
   assign system_clock_o = sys_edge;
   assign instruction_clock_o = instruction_clock;
   assign fast_osc_enable_o = fast_run;
   assign slow_osc_enable_o = slow_run;
   assign slow_osc_rc_mode_o = opt_reg[`CRC_OPT_SLOW_RC_BIT];
   assign osc_output_pin_o = sq_wave & rc_mode;
   assign osc_output_pin_oe_o = rc_mode;
   assign cpu_run_o = ~sys_rst & (cpu_mode == CPU_NORMAL);
   assign green_mode_o = (cpu_mode == CPU_GREEN);
   assign sleep_mode_o = sleeping;
   assign slow_mode_o = slow_sel;
   assign watchdog_clear_o = oscillator_mode_control_reg[`CRC_OSCILLATOR_MODE_CONTROL_WD_CLEAR_BIT];
   assign watchdog_period_select_o = oscillator_mode_control_reg[`CRC_OSCILLATOR_MODE_CONTROL_WD_RATE_BIT];
   assign rtc_period_o = rtc_sel;

endmodule

/* rtl/crc_regs.svh */
`ifndef CRC_REGS_SVH
`define CRC_REGS_SVH

// Register indices; byte address is four times the index
`define CRC_IDX_STATUS 10'h000
`define CRC_IDX_OPTION 10'h088
`define CRC_IDX_OSCILLATOR_MODE_CONTROL 10'h0CA

// Clock option register fields
`define CRC_OPT_SLOW_RC_BIT 0
`define CRC_OPT_RTC_LO_BIT 2
`define CRC_OPT_RTC_HI_BIT 3
`define CRC_OPT_RESET 8'h00
`define CRC_OPT_WMASK 8'h0D

// Oscillator mode register fields
`define CRC_OSCILLATOR_MODE_CONTROL_FAST_STOP_BIT 1
`define CRC_OSCILLATOR_MODE_CONTROL_SLOW_SEL_BIT 2
`define CRC_OSCILLATOR_MODE_CONTROL_CPU_LO_BIT 3
`define CRC_OSCILLATOR_MODE_CONTROL_CPU_HI_BIT 4
`define CRC_OSCILLATOR_MODE_CONTROL_WD_RATE_BIT 5
`define CRC_OSCILLATOR_MODE_CONTROL_WD_CLEAR_BIT 6
`define CRC_OSCILLATOR_MODE_CONTROL_WD_SRC_BIT 7
`define CRC_OSCILLATOR_MODE_CONTROL_RESET 8'h00
`define CRC_OSCILLATOR_MODE_CONTROL_WMASK 8'hFE

// Instruction clock dividers
`define CRC_INSTRUCTION_CLOCK_DIV 4
`define CRC_INSTRUCTION_CLOCK_DIV_HALVED 8

// Real-time clock base: slow oscillator rate and shortest period
`define CRC_SLOW_OSC_HZ 32768
`define CRC_RTC_BASE_MS 500
`define CRC_RTC_BASE_EDGES (`CRC_SLOW_OSC_HZ * `CRC_RTC_BASE_MS / 1000)

`endif

/* rtl/crc_pkg.sv */
package crc_pkg;

   // Clock source switch states, Gray along the loop
   typedef enum logic [1:0] {
      SW_FAST = 2'b00,
      SW_TO_SLOW = 2'b01,
      SW_SLOW = 2'b11,
      SW_TO_FAST = 2'b10
   } crc_switch_e;

   typedef enum logic [1:0] {
      CPU_NORMAL = 2'b00,
      CPU_SLEEP = 2'b01,
      CPU_GREEN = 2'b10,
      CPU_RESERVED = 2'b11
   } crc_cpu_mode_e;

   typedef enum logic [1:0] {
      OSC_RC = 2'b00,
      OSC_XTAL_32K = 2'b01,
      OSC_XTAL_12M = 2'b10,
      OSC_XTAL_4M = 2'b11
   } crc_osc_type_e;

   typedef logic [7:0] crc_reg_t;

endpackage

/* rtl/crc_osc_sync.sv */
module crc_osc_sync #(
   parameter int WIDTH = 3
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Asynchronous oscillator levels
   input wire logic [WIDTH-1:0] osc_i,
   // Synchronised level and rising-edge pulse
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] rise_o
);
   import crc_pkg::*;

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] stable;
   logic [WIDTH-1:0] prev;
   logic [WIDTH-1:0] next_rise;

   initial begin
      if (WIDTH < 1) begin
         $error("crc_osc_sync: WIDTH must be at least 1");
      end
   end

   generate
      for (genvar i = 0; i < WIDTH; i++) begin : g_bit
         always_comb begin
            next_rise[i] = stable[i] & ~prev[i];
         end
      end
   endgenerate

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= '0;
         stable <= '0;
         prev <= '0;
         rise_o <= '0;
      end else begin
         meta <= osc_i;
         stable <= meta;
         prev <= stable;
         rise_o <= next_rise;
      end
   end

   assign level_o = prev;

endmodule

/* tb/crc_props.sv */
`include "crc_regs.svh"

module crc_props (
   // Clock and resets
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic reset_pin_n_i,
   input wire logic low_supply_detector_i,
   input wire logic system_reset_o,
   // Clocks and modes
   input wire logic system_clock_o,
   input wire logic instruction_clock_o,
   input wire logic watchdog_tick_o,
   input wire logic fast_osc_enable_o,
   input wire logic slow_osc_enable_o,
   input wire logic slow_osc_rc_mode_o,
   input wire logic slow_mode_o,
   input wire logic green_mode_o,
   input wire logic sleep_mode_o,
   input wire logic [1:0] rtc_period_o,
   // Bus
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i
);
   timeunit 1ns;
   timeprecision 10ps;
   logic take, wr_opt, wr_osc, wd_src, seen;
   logic next_wr_opt, next_wr_osc, next_wd_src, next_seen;
   logic [3:0] cnt, next_cnt;
   logic [7:0] wbyte, next_wbyte;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   always_comb begin
      take = hsel_i && hready_i && htrans_i[1] && hwrite_i;
      next_wr_opt = take && (haddr_i[11:2] == `CRC_IDX_OPTION);
      next_wr_osc = take && (haddr_i[11:2] == `CRC_IDX_OSCILLATOR_MODE_CONTROL);
      next_wd_src = system_reset_o ? 1'b0 : (wr_osc ? hwdata_i[7] : wd_src);
      next_seen = !system_reset_o && (seen || instruction_clock_o);
      next_cnt = (system_reset_o || instruction_clock_o) ? 4'h0 : cnt + 4'(system_clock_o);
      next_wbyte = hwdata_i[7:0];
   end
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         {wr_opt, wr_osc, wd_src, seen, cnt, wbyte} <= '0;
      end else begin
         {wr_opt, wr_osc, wd_src, seen} <= {next_wr_opt, next_wr_osc, next_wd_src, next_seen};
         {cnt, wbyte} <= {next_cnt, next_wbyte};
      end
   end
   AST_PIN_RESET: assert property (!reset_pin_n_i |-> ##[1:4] system_reset_o)
      else $error("pin reset not applied");
   AST_LOW_SUPPLY: assert property (low_supply_detector_i |-> ##[1:4] system_reset_o)
      else $error("low supply reset not applied");
   AST_RELEASE: assert property ((reset_pin_n_i && !low_supply_detector_i) [*4]
      |=> !system_reset_o)
      else $error("system reset not released");
   AST_NO_GLITCH: assert property (system_clock_o |=> !system_clock_o)
      else $error("system clock pulses back to back");
   AST_DIVIDE: assert property (instruction_clock_o && seen
      |-> (cnt + 4'(system_clock_o)) inside {4'h4, 4'h8})
      else $error("instruction clock divide wrong");
   AST_SLEEP_OSC: assert property (sleep_mode_o |-> !fast_osc_enable_o && !slow_osc_enable_o)
      else $error("oscillator runs in sleep");
   AST_SLOW_RUNS: assert property (!sleep_mode_o |-> slow_osc_enable_o)
      else $error("slow oscillator stopped");
   AST_OPT_WRITE: assert property (wr_opt && !system_reset_o
      |=> slow_osc_rc_mode_o == wbyte[0] && rtc_period_o == wbyte[3:2])
      else $error("option write not applied");
   AST_OSCILLATOR_MODE_CONTROL_WRITE: assert property (wr_osc && !system_reset_o |=> slow_mode_o == wbyte[2]
      && green_mode_o == (wbyte[4:3] == 2'b10) && sleep_mode_o == (wbyte[4:3] == 2'b01))
      else $error("mode write not applied");
   AST_RESET_VALUES: assert property (system_reset_o |=> rtc_period_o == 2'b00
      && !slow_osc_rc_mode_o && !slow_mode_o && !green_mode_o && !sleep_mode_o)
      else $error("register not at initial value");
   AST_WD_SOURCE: assert property (!wd_src && !$past(wd_src)
      |-> watchdog_tick_o == $past(instruction_clock_o))
      else $error("watchdog tick not from instruction clock");
endmodule

bind crc_top crc_props i_crc_props (.clock_i, .rst_i, .reset_pin_n_i, .low_supply_detector_i,
   .system_reset_o, .system_clock_o, .instruction_clock_o, .watchdog_tick_o, .fast_osc_enable_o,
   .slow_osc_enable_o, .slow_osc_rc_mode_o, .slow_mode_o, .green_mode_o, .sleep_mode_o,
   .rtc_period_o, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i);

/* tb/crc_osc_model.sv */
module crc_osc_model #(
   parameter real FAST_HALF = 61.37,
   parameter real SLOW_HALF = 231.71,
   parameter real RC_HALF = 173.93
) (
   // Enables from the block
   input wire logic fast_en_i,
   input wire logic slow_en_i,
   // Oscillator levels
   output logic fast_osc_o,
   output logic slow_osc_o,
   output logic rc_osc_o
);
   timeunit 1ns;
   timeprecision 10ps;
   initial begin
      fast_osc_o = 1'b0;
      slow_osc_o = 1'b0;
      rc_osc_o = 1'b0;
   end
   // A stopped oscillator holds its level
   always #(FAST_HALF) if (fast_en_i === 1'b1) fast_osc_o = ~fast_osc_o;
   always #(SLOW_HALF) if (slow_en_i === 1'b1) slow_osc_o = ~slow_osc_o;
   always #(RC_HALF) rc_osc_o = ~rc_osc_o;
endmodule

/* tb/tb.sv */
`include "crc_regs.svh"

module tb;
   timeunit 1ns;
   timeprecision 10ps;
   localparam logic [31:0] A_OPT = 32'(`CRC_IDX_OPTION) << 2;
   localparam logic [31:0] A_OSC = 32'(`CRC_IDX_OSCILLATOR_MODE_CONTROL) << 2;
   localparam logic [31:0] A_STAT = 32'(`CRC_IDX_STATUS) << 2;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic reset_pin_n_i = 1'b1;
   logic low_supply_detector_i = 1'b0;
   crc_pkg::crc_osc_type_e fast_osc_type_i = crc_pkg::OSC_XTAL_4M;
   logic clock_halve_i = 1'b0;
   logic basic_timer_timebase_select_i = 1'b0;
   logic wakeup_i = 1'b0;
   logic hsel_i = 1'b0;
   logic hwrite_i = 1'b0;
   logic [1:0] htrans_i = 2'h0;
   logic [2:0] hsize_i = 3'h2;
   logic [31:0] haddr_i = 32'h0;
   logic [31:0] hwdata_i = 32'h0;
   logic fast_oscillator_i, slow_oscillator_i, internal_rc_i, system_reset_o;
   logic fast_osc_enable_o, slow_osc_enable_o, slow_osc_rc_mode_o, osc_output_pin_o;
   logic osc_output_pin_oe_o, system_clock_o, instruction_clock_o, watchdog_tick_o;
   logic basic_timer_tick_o, cpu_run_o, green_mode_o, sleep_mode_o, slow_mode_o;
   logic watchdog_clear_o, watchdog_period_select_o, hreadyout_o, hresp_o;
   logic [1:0] rtc_period_o;
   logic [31:0] hrdata_o, rd;
   int failures = 0, check_count = 0, scnt = 0, fcnt = 0, lcnt = 0, ocnt = 0;

   crc_top #(.RTC_BASE_EDGES(4)) i_crc_top (.clock_i, .rst_i, .reset_pin_n_i,
      .low_supply_detector_i, .system_reset_o, .fast_osc_type_i, .clock_halve_i,
      .fast_oscillator_i, .slow_oscillator_i, .internal_rc_i, .fast_osc_enable_o,
      .slow_osc_enable_o, .slow_osc_rc_mode_o, .osc_output_pin_o, .osc_output_pin_oe_o,
      .system_clock_o, .instruction_clock_o, .watchdog_tick_o, .basic_timer_tick_o,
      .basic_timer_timebase_select_i, .wakeup_i, .cpu_run_o, .green_mode_o, .sleep_mode_o,
      .slow_mode_o, .watchdog_clear_o, .watchdog_period_select_o, .rtc_period_o, .hsel_i,
      .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o),
      .hreadyout_o, .hresp_o, .hrdata_o);
   crc_osc_model i_crc_osc_model (.fast_en_i(fast_osc_enable_o), .slow_en_i(slow_osc_enable_o),
      .fast_osc_o(fast_oscillator_i), .slow_osc_o(slow_oscillator_i), .rc_osc_o(internal_rc_i));

   always #10 clock_i = ~clock_i;
   always @(posedge clock_i) if (system_clock_o === 1'b1) scnt <= scnt + 1;
   always @(posedge fast_oscillator_i) fcnt <= fcnt + 1;
   always @(posedge slow_oscillator_i) lcnt <= lcnt + 1;
   always @(posedge osc_output_pin_o) ocnt <= ocnt + 1;

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         failures++;
         $display("[FAIL] %s expected %0h seen %0h", nm, want, seen);
      end
   endtask
   function automatic logic sig(input int w);
      case (w)
         0: return instruction_clock_o;
         1: return basic_timer_tick_o;
         2: return system_reset_o;
         default: return hreadyout_o;
      endcase
   endfunction
   task automatic wait_hi(input int w, input logic lvl);
      int n;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (sig(w) !== lvl && n < 20000);
      if (n >= 20000) begin
         failures++;
         stop_test();
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel_i <= 1'b1;
      htrans_i <= 2'b10;
      haddr_i <= a;
      hwrite_i <= wr;
      wait_hi(3, 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'b00;
      hwdata_i <= wd;
      wait_hi(3, 1'b1);
      rd = hrdata_o;
   endtask
   task automatic poll_sw(input logic [1:0] st);
      int n;
      n = 0;
      do begin
         bus(1'b0, A_STAT, 32'h0);
         n++;
      end while (rd[1:0] !== st && n < 50);
      chk("switch_state", 32'(rd[1:0]), 32'(st));
   endtask
   task automatic t_regs();
      bus(1'b0, A_OPT, 32'h0);
      chk("option_init", rd, 32'h0);
      bus(1'b1, A_OPT, 32'hFFFF_FFFF);
      bus(1'b0, A_OPT, 32'h0);
      chk("option", rd, 32'h0000_000D);
      chk("slow_rc", 32'(slow_osc_rc_mode_o), 32'h1);
      chk("hresp", 32'(hresp_o), 32'h0);
      bus(1'b1, 32'h0000_0100, 32'hFF);
      bus(1'b0, 32'h0000_0100, 32'h0);
      chk("unmapped", rd, 32'h0);
      bus(1'b1, A_OSC, 32'hE4);
      poll_sw(2'b11);
      bus(1'b1, A_OSC, 32'hE6);
      bus(1'b0, A_OSC, 32'h0);
      chk("oscillator_mode_control", rd, 32'h0000_00E6);
      chk("fast_stop", 32'({fast_osc_enable_o, slow_osc_enable_o, slow_mode_o}), 32'h3);
      wait_hi(0, 1'b1);
      bus(1'b1, A_OSC, 32'h0);
      poll_sw(2'b00);
   endtask
   task automatic t_modes();
      logic [4:0] want [4];
      logic [4:0] v;
      want = '{5'b10011, 5'b00100, 5'b01011, 5'b00011};
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, A_OSC, 32'(m << 3));
         @(posedge clock_i);
         v = {cpu_run_o, green_mode_o, sleep_mode_o, fast_osc_enable_o, slow_osc_enable_o};
         chk("cpu_mode", 32'(v), 32'(want[m]));
         if (m == 1 || m == 2) begin
            wakeup_i <= 1'b1;
            @(posedge clock_i);
            wakeup_i <= 1'b0;
            repeat (2) @(posedge clock_i);
            chk("wakeup", 32'(cpu_run_o), 32'h1);
         end
      end
      bus(1'b1, A_OSC, 32'h0);
   endtask
   task automatic t_reset();
      bus(1'b1, A_OSC, 32'h64);
      bus(1'b0, A_OSC, 32'h0);
      chk("wd_bits_set", 32'({watchdog_clear_o, watchdog_period_select_o}), 32'h3);
      low_supply_detector_i <= 1'b1;
      reset_pin_n_i <= 1'b0;
      wait_hi(2, 1'b1);
      low_supply_detector_i <= 1'b0;
      repeat (10) @(posedge clock_i);
      chk("pin_held", 32'(system_reset_o), 32'h1);
      reset_pin_n_i <= 1'b1;
      wait_hi(2, 1'b0);
      bus(1'b0, A_OSC, 32'h0);
      chk("oscillator_mode_control_init", rd, 32'h0);
      chk("wd_bits_init", 32'({watchdog_clear_o, watchdog_period_select_o}), 32'h0);
      bus(1'b1, A_OSC, 32'h04);
      low_supply_detector_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      low_supply_detector_i <= 1'b0;
      wait_hi(2, 1'b1);
      wait_hi(2, 1'b0);
      chk("slow_cleared", 32'(slow_mode_o), 32'h0);
   endtask
   task automatic t_div();
      int d, s0, f0, o0;
      for (int k = 0; k < 4; k++) begin
         fast_osc_type_i <= crc_pkg::crc_osc_type_e'(k);
         clock_halve_i <= (k == 2);
         reset_pin_n_i <= 1'b0;
         wait_hi(2, 1'b1);
         reset_pin_n_i <= 1'b1;
         wait_hi(2, 1'b0);
         d = (k == 0 || k == 2) ? 8 : 4;
         bus(1'b0, A_STAT, 32'h0);
         chk("opt_latch", 32'(rd[6:4]), 32'({d == 8, 2'(k)}));
         chk("rc_pin_oe", 32'(osc_output_pin_oe_o), 32'(k == 0));
         wait_hi(0, 1'b1);
         s0 = scnt;
         f0 = fcnt;
         o0 = ocnt;
         repeat (4) wait_hi(0, 1'b1);
         chk("instruction_clock_div", 32'(scnt - s0), 32'(4 * d));
         chk("rc_halve", 32'((fcnt - f0) * 2 > (scnt - s0) * 3), 32'(k == 0));
         chk("rc_wave", 32'(ocnt - o0), 32'((k == 0) ? 4 : 0));
         @(posedge clock_i);
         chk("timer_tick", 32'(basic_timer_tick_o), 32'h1);
      end
   endtask
   task automatic t_rtc();
      int l0;
      basic_timer_timebase_select_i <= 1'b1;
      for (int p = 0; p < 4; p++) begin
         bus(1'b1, A_OPT, 32'(p << 2));
         @(posedge clock_i);
         chk("rtc_field", 32'(rtc_period_o), 32'(p));
         wait_hi(1, 1'b1);
         l0 = lcnt;
         wait_hi(1, 1'b1);
         chk("rtc_edges", 32'(lcnt - l0), 32'(4 << p));
      end
   endtask

   initial begin
      repeat (12) @(posedge clock_i);
      rst_i <= 1'b0;
      wait_hi(2, 1'b0);
      t_regs();
      t_modes();
      t_reset();
      t_div();
      t_rtc();
      stop_test();
   end
endmodule
